//--- design/emsd_pkg.sv
package emsd_pkg;
    // selector bit positions, position 8 (index 7) is ignored
    localparam int EMSD_POS_AREA10_EXT = 0;
    localparam int EMSD_POS_AREA9_17 = 1;
    localparam int EMSD_POS_AREA8_14 = 2;
    localparam int EMSD_POS_AREA7_13 = 3;
    localparam int EMSD_POS_AREA6_78 = 4;
    localparam int EMSD_POS_AREA5_15 = 5;
    localparam int EMSD_POS_AREA4_11 = 6;
    localparam int EMSD_SEL_W = 8;
    localparam int EMSD_AREA_W = 7;
    localparam int EMSD_ADDR_W = 24;
    localparam int EMSD_CODE_LSB = 21;
    localparam int EMSD_CODE_MSB = 22;
    // default selector settings
    localparam logic [7:0] EMSD_SEL_RAM_DEF = 8'h01;
    localparam logic [7:0] EMSD_SEL_FLASH_DEF = 8'h00;
    localparam logic [7:0] EMSD_SEL_LOGIC_DEF = 8'h02;
    // default start code switches: bit0 set 1, bit1 set 2, bit2 set 3, bit3 set 4
    localparam logic [3:0] EMSD_CODE_SW_DEF = 4'h1;
    // break pulse length in clk cycles
    localparam logic [3:0] EMSD_BREAK_CYCLES = 4'h4;
endpackage

//--- design/emsd_area_match.sv
`timescale 1ns/1ps
module emsd_area_match
    import emsd_pkg::*;
(
    input wire logic [emsd_pkg::EMSD_SEL_W-1:0] selector,
    input wire logic [emsd_pkg::EMSD_AREA_W-1:0] area_active,
    output logic hit
);
    // position 8 never takes part; all off means the block is unused
    always_comb
    begin
        hit = |(selector[EMSD_AREA_W-1:0] & area_active); // [RL1] [RL2] [RL9]
    end
endmodule

//--- design/emsd_decoder.sv
`timescale 1ns/1ps
// Function
// RL1 - selector positions 1..7 pick areas, 8 ignored
// RL2 - all positions off: block never responds
// RL3 - configurer turns on at most one position
// RL4 - RAM responds on select and matching A22:21
// RL5 - start code is inverse of switch pair
// RL6 - defaults: RAM area10, flash unused, logic area9
// RL7 - defaults give codes 10 and 11
// RL8 - flash decodes chip-select only
// RL9 - logic blocks each use own selector
// RL10 - protect disabled: RAM always read/write
// RL11 - probe drives protect input definite level
// RL12 - protect enabled: low input means read only
// RL13 - break output pulses low, else released
// RL14 - configurer avoids overlapping areas
// RL15 - cascaded boards use distinct codes
// RL16 - address bit 23 and above ignored
// RL17 - protected writes suppressed, cycle completes
module emsd_decoder
    import emsd_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic area10_ext_select_n,
    input wire logic area9_17_select_n,
    input wire logic area8_14_select_n,
    input wire logic area7_13_select_n,
    input wire logic area6_78_select_n,
    input wire logic area5_15_select_n,
    input wire logic area4_11_select_n,
    input wire logic [emsd_pkg::EMSD_ADDR_W-1:0] addr,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [emsd_pkg::EMSD_SEL_W-1:0] ram0_area_selector,
    input wire logic [emsd_pkg::EMSD_SEL_W-1:0] ram1_area_selector,
    input wire logic [emsd_pkg::EMSD_SEL_W-1:0] flash_area_selector,
    input wire logic [emsd_pkg::EMSD_SEL_W-1:0] logic0_area_selector,
    input wire logic [emsd_pkg::EMSD_SEL_W-1:0] logic1_area_selector,
    input wire logic [3:0] ram_start_code_switches,
    input wire logic write_protect_enable,
    input wire logic protect_input,
    input wire logic break_request,
    output logic ram0_sel,
    output logic ram1_sel,
    output logic flash_sel,
    output logic logic0_sel,
    output logic logic1_sel,
    output logic ram_rd_en,
    output logic ram_wr_en,
    output logic ram_wr_blocked,
    output logic break_output_o,
    output logic break_output_oe
);
    import emsd_pkg::*;

    // two-stage synchronisers for every pin input
    localparam int SW = 7 + 24 + 2 + 40 + 4 + 2 + 1;
    // idle bus (strobes high, no select) and the default switch settings
    localparam logic [SW-1:0] SYNC_RST = {7'h00, 24'h000000, 1'b1, 1'b1,
        EMSD_SEL_RAM_DEF, EMSD_SEL_RAM_DEF, EMSD_SEL_FLASH_DEF, EMSD_SEL_LOGIC_DEF,
        EMSD_SEL_LOGIC_DEF, EMSD_CODE_SW_DEF, 1'b0, 1'b0, 1'b0}; // [RL6] [RL7]
    logic [SW-1:0] raw;
    logic [SW-1:0] meta_ff;
    logic [SW-1:0] sync_ff;
    assign raw = {~area4_11_select_n, ~area5_15_select_n, ~area6_78_select_n,
        ~area7_13_select_n, ~area8_14_select_n, ~area9_17_select_n,
        ~area10_ext_select_n, addr, rd_n, wr_n, ram0_area_selector,
        ram1_area_selector, flash_area_selector, logic0_area_selector,
        logic1_area_selector, ram_start_code_switches, write_protect_enable,
        protect_input, break_request};

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            // reset value corresponds to idle bus and default switches
            meta_ff <= SYNC_RST; // [RL6]
            sync_ff <= SYNC_RST; // [RL6]
        end
        else
        begin
            meta_ff <= raw;
            sync_ff <= meta_ff;
        end
    end

    logic [6:0] s_area;
    logic [23:0] s_addr;
    logic s_rd_n;
    logic s_wr_n;
    logic [7:0] s_sel_r0;
    logic [7:0] s_sel_r1;
    logic [7:0] s_sel_fl;
    logic [7:0] s_sel_l0;
    logic [7:0] s_sel_l1;
    logic [3:0] s_code_sw;
    logic s_wp_en;
    logic s_prot;
    logic s_brk;
    assign {s_area, s_addr, s_rd_n, s_wr_n, s_sel_r0, s_sel_r1, s_sel_fl, s_sel_l0,
        s_sel_l1, s_code_sw, s_wp_en, s_prot, s_brk} = sync_ff;

    logic hit_r0;
    logic hit_r1;
    logic hit_fl;
    logic hit_l0;
    logic hit_l1;
    emsd_area_match u_r0 (.selector(s_sel_r0), .area_active(s_area), .hit(hit_r0));
    emsd_area_match u_r1 (.selector(s_sel_r1), .area_active(s_area), .hit(hit_r1));
    emsd_area_match u_fl (.selector(s_sel_fl), .area_active(s_area), .hit(hit_fl));
    emsd_area_match u_l0 (.selector(s_sel_l0), .area_active(s_area), .hit(hit_l0));
    emsd_area_match u_l1 (.selector(s_sel_l1), .area_active(s_area), .hit(hit_l1));

    // switch on = 1; code is inverted, second setting is the high bit
    logic [1:0] code0;
    logic [1:0] code1;
    logic [1:0] a_code;
    assign code0 = ~{s_code_sw[1], s_code_sw[0]}; // [RL5] [RL7]
    assign code1 = ~{s_code_sw[3], s_code_sw[2]}; // [RL5] [RL7]
    // bit 23 and above never compared, so each code shows twice per area
    assign a_code = s_addr[EMSD_CODE_MSB:EMSD_CODE_LSB]; // [RL16]

    logic nxt_ram0_sel;
    logic nxt_ram1_sel;
    logic nxt_flash_sel;
    logic nxt_logic0_sel;
    logic nxt_logic1_sel;
    logic nxt_ram_rd_en;
    logic nxt_ram_wr_en;
    logic nxt_ram_wr_blocked;
    logic ram_any;
    logic wr_allowed;

    always_comb
    begin
        nxt_ram0_sel = hit_r0 && (a_code == code0); // [RL4]
        nxt_ram1_sel = hit_r1 && (a_code == code1); // [RL4]
        nxt_flash_sel = hit_fl; // [RL8]
        nxt_logic0_sel = hit_l0; // [RL9]
        nxt_logic1_sel = hit_l1; // [RL9]
        ram_any = nxt_ram0_sel || nxt_ram1_sel;
        // protect input high means target halted
        wr_allowed = !s_wp_en || s_prot; // [RL10] [RL12]
        nxt_ram_rd_en = ram_any && !s_rd_n;
        // select still asserted so the bus cycle completes normally
        nxt_ram_wr_en = ram_any && !s_wr_n && wr_allowed; // [RL17]
        nxt_ram_wr_blocked = ram_any && !s_wr_n && !wr_allowed; // [RL17]
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            ram0_sel <= 1'b0;
            ram1_sel <= 1'b0;
            flash_sel <= 1'b0;
            logic0_sel <= 1'b0;
            logic1_sel <= 1'b0;
            ram_rd_en <= 1'b0;
            ram_wr_en <= 1'b0;
            ram_wr_blocked <= 1'b0;
        end
        else
        begin
            ram0_sel <= nxt_ram0_sel;
            ram1_sel <= nxt_ram1_sel;
            flash_sel <= nxt_flash_sel;
            logic0_sel <= nxt_logic0_sel;
            logic1_sel <= nxt_logic1_sel;
            ram_rd_en <= nxt_ram_rd_en;
            ram_wr_en <= nxt_ram_wr_en;
            ram_wr_blocked <= nxt_ram_wr_blocked;
        end
    end

    // break pulse: one low pulse per rising request seen while idle, released otherwise
    typedef enum logic [0:0] {EMSD_BRK_IDLE = 1'b0, EMSD_BRK_PULSE = 1'b1} emsd_brk_t;
    emsd_brk_t brk_state_ff;
    emsd_brk_t nxt_brk_state;
    logic [3:0] brk_cnt_ff;
    logic [3:0] nxt_brk_cnt;
    logic brk_prev_ff;
    logic nxt_brk_oe;

    always_comb
    begin
        nxt_brk_state = brk_state_ff;
        nxt_brk_cnt = brk_cnt_ff;
        nxt_brk_oe = 1'b0;
        case (brk_state_ff)
            EMSD_BRK_IDLE:
            begin
                if (s_brk && !brk_prev_ff)
                begin
                    nxt_brk_state = EMSD_BRK_PULSE; // [RL13]
                    nxt_brk_cnt = EMSD_BREAK_CYCLES;
                    nxt_brk_oe = 1'b1;
                end
            end
            EMSD_BRK_PULSE:
            begin
                nxt_brk_cnt = brk_cnt_ff - 4'h1;
                nxt_brk_oe = (brk_cnt_ff != 4'h1);
                if (brk_cnt_ff == 4'h1)
                begin
                    nxt_brk_state = EMSD_BRK_IDLE;
                end
            end
            default:
            begin
                nxt_brk_state = EMSD_BRK_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            brk_state_ff <= EMSD_BRK_IDLE;
            brk_cnt_ff <= 4'h0;
            brk_prev_ff <= 1'b0;
            break_output_oe <= 1'b0;
            break_output_o <= 1'b0;
        end
        else
        begin
            brk_state_ff <= nxt_brk_state;
            brk_cnt_ff <= nxt_brk_cnt;
            brk_prev_ff <= s_brk;
            break_output_oe <= nxt_brk_oe; // [RL13]
            break_output_o <= 1'b0;
        end
    end

    ram_wp_a: assert property (@(posedge clk) disable iff (reset)
        (s_wp_en && !s_prot) |=> !ram_wr_en) // [RL12]
        else $error("ram write allowed while protected");
    ram_wp_off_a: assert property (@(posedge clk) disable iff (reset)
        (!s_wp_en && nxt_ram0_sel && !s_wr_n) |=> ram_wr_en) // [RL10]
        else $error("ram write refused with protect off");
    ram_blk_a: assert property (@(posedge clk) disable iff (reset)
        ram_wr_blocked |-> (ram0_sel || ram1_sel) && !ram_wr_en) // [RL17]
        else $error("blocked write without select");
    ram0_code_a: assert property (@(posedge clk) disable iff (reset)
        (hit_r0 && a_code != code0) |=> !ram0_sel) // [RL4]
        else $error("ram0 selected on wrong code");
    unused_blk_a: assert property (@(posedge clk) disable iff (reset)
        (s_sel_fl[6:0] == 7'h00) |=> !flash_sel) // [RL2]
        else $error("unused flash responded");
    pos8_ign_a: assert property (@(posedge clk) disable iff (reset)
        (s_sel_l0 == 8'h80) |=> !logic0_sel) // [RL1]
        else $error("position 8 selected a logic block");
    brk_pulse_a: assert property (@(posedge clk) disable iff (reset)
        (brk_state_ff == EMSD_BRK_IDLE && s_brk && !brk_prev_ff)
        |=> break_output_oe [*4] ##1 !break_output_oe) // [RL13]
        else $error("break pulse length wrong");
    code_inv_a: assert property (@(posedge clk) disable iff (reset)
        (s_code_sw[1:0] == 2'b01) |-> code0 == 2'b10) // [RL5]
        else $error("start code not inverted");
endmodule

//--- verification/emsd_bus_model.sv
`timescale 1ns/1ps
module emsd_bus_model
    import emsd_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic cyc,
    input wire logic [2:0] area,
    input wire logic [emsd_pkg::EMSD_ADDR_W-1:0] a,
    input wire logic wr,
    input wire logic halted,
    output logic [emsd_pkg::EMSD_AREA_W-1:0] cs_n,
    output logic [emsd_pkg::EMSD_ADDR_W-1:0] addr,
    output logic rd_n,
    output logic wr_n,
    output logic protect_input
);
    // launches on the rising edge so the bench command set at the falling edge never races
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            cs_n <= '1;
            addr <= '0;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            protect_input <= 1'b0;
        end
        else
        begin
            // area 7 selects nothing: the shift falls off the top
            cs_n <= cyc ? ~(7'h01 << area) : '1;
            // released bus never keeps the old address
            addr <= cyc ? a : ~addr;
            rd_n <= !(cyc && !wr);
            wr_n <= !(cyc && wr);
            protect_input <= halted;
        end
    end
endmodule

//--- verification/emsd_decoder_test.sv
`timescale 1ns/1ps
module emsd_decoder_test;
    import emsd_pkg::*;
    typedef struct {
        logic [7:0] s0, s1, fl, l0, l1;
        logic [3:0] sw;
        logic [2:0] area;
        logic [23:0] a;
        logic wr, wpe, prot;
        logic [7:0] exp;
    } emsd_row_t;
    logic clk = 0, reset = 1, cyc = 0, wr = 0, halted = 0, wpe = 0, brk = 0;
    logic [2:0] area = 0;
    logic [23:0] a = 0, addr;
    logic [7:0] s0 = 0, s1 = 0, fl = 0, l0 = 0, l1 = 0;
    logic [3:0] sw = 0;
    logic [6:0] cs_n;
    logic rd_n, wr_n, prot_in, r0, r1, fs, g0, g1, rde, wre, blk, bo, boe;
    wire logic [7:0] outs = {r0, r1, fs, g0, g1, rde, wre, blk};
    int n_fail = 0, checks_done = 0, cnt;
    emsd_row_t r;
    // config rows keep at most one position per selector; logic0 and logic1 overlap on position 2 in the first 14 rows
    // the two RAM blocks always get distinct codes in one area
    emsd_row_t rows [16] = '{
        '{8'h01, 8'h01, 8'h00, 8'h02, 8'h02, 4'h1, 3'h0, 24'hC00000, 0, 0, 0, 8'h84},
        '{8'h01, 8'h01, 8'h00, 8'h02, 8'h02, 4'h1, 3'h0, 24'hDFFFFF, 0, 0, 0, 8'h84},
        '{8'h01, 8'h01, 8'h00, 8'h02, 8'h02, 4'h1, 3'h0, 24'hE00000, 0, 0, 0, 8'h44},
        '{8'h01, 8'h01, 8'h00, 8'h02, 8'h02, 4'h1, 3'h0, 24'h400000, 0, 0, 0, 8'h84},
        '{8'h01, 8'h01, 8'h00, 8'h02, 8'h02, 4'h1, 3'h0, 24'hA00000, 0, 0, 0, 8'h00},
        '{8'h01, 8'h01, 8'h00, 8'h02, 8'h02, 4'h1, 3'h1, 24'hC00000, 0, 0, 0, 8'h18},
        '{8'h01, 8'h01, 8'h00, 8'h02, 8'h02, 4'h1, 3'h0, 24'hC00000, 1, 0, 0, 8'h82},
        '{8'h01, 8'h01, 8'h00, 8'h02, 8'h02, 4'h1, 3'h0, 24'hC00000, 1, 1, 1, 8'h82},
        '{8'h01, 8'h01, 8'h00, 8'h02, 8'h02, 4'h1, 3'h0, 24'hC00000, 1, 1, 0, 8'h81},
        '{8'h01, 8'h01, 8'h00, 8'h02, 8'h02, 4'h1, 3'h0, 24'hC00000, 0, 1, 0, 8'h84},
        '{8'h01, 8'h01, 8'h00, 8'h02, 8'h02, 4'h6, 3'h0, 24'h200000, 0, 0, 0, 8'h84},
        '{8'h01, 8'h01, 8'h00, 8'h02, 8'h02, 4'h6, 3'h0, 24'h400000, 0, 0, 0, 8'h44},
        '{8'h01, 8'h01, 8'h00, 8'h02, 8'h02, 4'h9, 3'h0, 24'hA00000, 0, 0, 0, 8'h44},
        '{8'h01, 8'h01, 8'h40, 8'h02, 8'h02, 4'h1, 3'h6, 24'h000000, 0, 0, 0, 8'h20},
        '{8'h01, 8'h01, 8'h00, 8'h04, 8'h10, 4'h1, 3'h2, 24'hC00000, 0, 0, 0, 8'h10},
        '{8'h01, 8'h01, 8'h00, 8'h04, 8'h10, 4'h1, 3'h4, 24'hC00000, 0, 0, 0, 8'h08}};

    always #5 clk = ~clk;

    emsd_bus_model i_bus (.clk(clk), .reset(reset), .cyc(cyc), .area(area), .a(a), .wr(wr),
        .halted(halted), .cs_n(cs_n), .addr(addr), .rd_n(rd_n), .wr_n(wr_n),
        .protect_input(prot_in));
    emsd_decoder i_dut (.clk(clk), .reset(reset), .area10_ext_select_n(cs_n[0]),
        .area9_17_select_n(cs_n[1]), .area8_14_select_n(cs_n[2]),
        .area7_13_select_n(cs_n[3]), .area6_78_select_n(cs_n[4]),
        .area5_15_select_n(cs_n[5]), .area4_11_select_n(cs_n[6]), .addr(addr),
        .rd_n(rd_n), .wr_n(wr_n), .ram0_area_selector(s0), .ram1_area_selector(s1),
        .flash_area_selector(fl), .logic0_area_selector(l0), .logic1_area_selector(l1),
        .ram_start_code_switches(sw), .write_protect_enable(wpe), .protect_input(prot_in),
        .break_request(brk), .ram0_sel(r0), .ram1_sel(r1), .flash_sel(fs),
        .logic0_sel(g0), .logic1_sel(g1), .ram_rd_en(rde), .ram_wr_en(wre),
        .ram_wr_blocked(blk), .break_output_o(bo), .break_output_oe(boe));

    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e)
        begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask

    task final_report;
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // model launch plus two sync stages plus output stage: five edges is safe
    task run(input emsd_row_t x);
        @(negedge clk);
        {s0, s1, fl, l0, l1, sw} = {x.s0, x.s1, x.fl, x.l0, x.l1, x.sw};
        {area, a, wr, wpe, halted, cyc} = {x.area, x.a, x.wr, x.wpe, x.prot, 1'b1};
        repeat (5) @(negedge clk);
    endtask

    initial
    begin
        repeat (8) @(negedge clk);
        chk("outs in reset", 8'h00, outs);
        reset = 0;
        for (int i = 0; i < 16; i++)
        begin
            run(rows[i]);
            chk("row", rows[i].exp, outs);
        end
        $display("table test done");
        r = rows[0];
        // logic blocks kept off the swept areas so nothing overlaps
        r.l0 = 8'h80;
        r.l1 = 8'h00;
        for (int k = 0; k < 8; k++)
        begin
            r.s0 = 8'h01 << k;
            r.s1 = 8'h00;
            r.area = (k == 7) ? 3'h0 : k[2:0];
            run(r);
            chk("ram0 own area", (k == 7) ? 8'h00 : 8'h84, outs);
            r.area = 3'((k + 1) % 7);
            run(r);
            chk("ram0 other area", 8'h00, outs);
        end
        r.s0 = 8'h00;
        r.area = 3'h0;
        run(r);
        chk("unused ram0", 8'h00, outs);
        $display("selector test done");
        run(rows[0]);
        @(negedge clk);
        reset = 1;
        @(negedge clk);
        chk("mid reset outs", 8'h00, outs);
        reset = 0;
        repeat (5) @(negedge clk);
        chk("after reset outs", 8'h84, outs);
        $display("reset test done");
        cnt = 0;
        brk = 1;
        for (int i = 0; i < 20; i++)
        begin
            @(negedge clk);
            if (boe === 1'b1)
                cnt++;
            if (boe === 1'b1)
                chk("break level", 8'h00, {7'h00, bo});
        end
        brk = 0;
        chk("break length", {4'h0, EMSD_BREAK_CYCLES}, cnt[7:0]);
        chk("break released", 8'h00, {7'h00, boe});
        $display("break test done");
        final_report;
    end
endmodule
